// >>> crypto_key_lifecycle_ctrl.sv
// Register bank and key routing of the security subsystem host interface
`timescale 1ns/1ps
module crypto_key_lifecycle_ctrl (
  // Clock, enable and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Subsystem control
  output logic subsystem_on,
  // AES key path
  output key_lifecycle_pkg::aes_key_t aes_key,
  // DMA length check
  output logic [15:0] dma_len,
  output logic dma_len_err
);

  // ********************************************************
  // Bus decode
  // ********************************************************
  logic access;
  logic wr;
  logic [11:0] addr_w;

  assign access = psel && penable && ce;
  assign wr = access && pwrite;
  assign addr_w = {paddr[11:2], 2'b00};

  function automatic logic in_range(input logic [11:0] a,
                                    input logic [11:0] base);
    in_range = (a >= base) && (a < base + 12'h010);
  endfunction

  function automatic logic [3:0] word_hot(input logic [11:0] a);
    word_hot = 4'h1 << a[3:2];
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == key_lifecycle_pkg::OFF_ENABLE) ||
             (a == key_lifecycle_pkg::OFF_LIFECYCLE) ||
             in_range(a, key_lifecycle_pkg::OFF_ROOT_KEY0) ||
             (a == key_lifecycle_pkg::OFF_KEY_STATUS) ||
             (a == key_lifecycle_pkg::OFF_KEY_SELECT) ||
             (a == key_lifecycle_pkg::OFF_HW_KEY_LOCK) ||
             in_range(a, key_lifecycle_pkg::OFF_SESSION_KEY0) ||
             (a == key_lifecycle_pkg::OFF_DMA_LEN) ||
             (a == key_lifecycle_pkg::OFF_DMA_STATUS);
  endfunction

  // ********************************************************
  // Retention domain
  // ********************************************************
  key_lifecycle_pkg::retention_t ret;
  logic [3:0] key_written;
  logic lc_we;
  logic lock_we;
  logic [3:0] key_we;
  logic secure_valid;

  assign secure_valid = ret.lc_valid &&
                        ret.lc_state == key_lifecycle_pkg::LC_SECURE;
  assign lc_we = wr && addr_w == key_lifecycle_pkg::OFF_LIFECYCLE;
  assign lock_we = wr && addr_w == key_lifecycle_pkg::OFF_HW_KEY_LOCK &&
                   pwdata[0];
  // Valid Secure state blocks a second write to the same word
  assign key_we = (wr && in_range(addr_w, key_lifecycle_pkg::OFF_ROOT_KEY0))
                  ? (word_hot(addr_w) & ~(secure_valid ? key_written : 4'h0))
                  : 4'h0;

  retention_domain u_ret (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .lc_we(lc_we),
    .lc_wdata(pwdata[3:0]),
    .lock_we(lock_we),
    .key_we(key_we),
    .key_wdata(pwdata),
    .ret(ret),
    .key_written(key_written)
  );

  // ********************************************************
  // Control registers
  // ********************************************************
  logic enable_q;
  key_lifecycle_pkg::key_sel_t key_sel_q;
  logic [127:0] session_key_q;
  logic [15:0] dma_len_q;
  logic dma_err_q;
  logic [3:0] sess_we;

  assign sess_we = in_range(addr_w, key_lifecycle_pkg::OFF_SESSION_KEY0)
                   ? word_hot(addr_w) : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= key_lifecycle_pkg::RST_ENABLE;
    end else if (wr && addr_w == key_lifecycle_pkg::OFF_ENABLE) begin
      enable_q <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_sel_q <= key_lifecycle_pkg::SEL_HARDWIRED;
    end else if (wr && addr_w == key_lifecycle_pkg::OFF_KEY_SELECT) begin
      unique case (pwdata[1:0])
        2'b00: key_sel_q <= key_lifecycle_pkg::SEL_HARDWIRED;
        2'b01: key_sel_q <= key_lifecycle_pkg::SEL_ROOT;
        default: key_sel_q <= key_lifecycle_pkg::SEL_SESSION;
      endcase
    end
  end

  genvar i;
  generate
    for (i = 0; i < key_lifecycle_pkg::KEY_WORDS; i++) begin : g_sess
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          session_key_q[32*i +: 32] <= 32'h0;
        end else if (wr && sess_we[i]) begin
          session_key_q[32*i +: 32] <= pwdata;
        end
      end
    end
  endgenerate

  // Length over 2^16-1 is refused and flagged, old length kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_len_q <= 16'h0;
      dma_err_q <= 1'b0;
    end else if (wr && addr_w == key_lifecycle_pkg::OFF_DMA_LEN) begin
      if (|pwdata[31:key_lifecycle_pkg::DMA_LEN_BITS]) begin
        dma_err_q <= 1'b1;
      end else begin
        dma_len_q <= pwdata[15:0];
        dma_err_q <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Key routing
  // ********************************************************
  key_lifecycle_pkg::aes_key_t aes_key_q;

  // Registered so no key bit ever goes through read mux logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aes_key_q <= '0;
    end else if (ce) begin
      aes_key_q.valid <= enable_q;
      unique case (key_sel_q)
        key_lifecycle_pkg::SEL_HARDWIRED: begin
          aes_key_q.key <= ret.hw_key_locked ? 128'h0 :
                           key_lifecycle_pkg::HARDWIRED_KEY;
        end
        key_lifecycle_pkg::SEL_ROOT: begin
          aes_key_q.key <= ret.root_key;
        end
        key_lifecycle_pkg::SEL_SESSION: begin
          aes_key_q.key <= session_key_q;
        end
        default: begin
          aes_key_q.key <= 128'h0;
        end
      endcase
    end
  end

  // ********************************************************
  // Read path and answer
  // ********************************************************
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic on_q;
  logic [15:0] dma_out_q;
  logic dma_err_out_q;

  // Key words read as zero: neither key can leak here
  always_comb begin
    rdata_d = 32'h0;
    if (addr_w == key_lifecycle_pkg::OFF_ENABLE) begin
      rdata_d[0] = enable_q;
    end else if (addr_w == key_lifecycle_pkg::OFF_LIFECYCLE) begin
      rdata_d[3:0] = ret.lc_state;
      rdata_d[key_lifecycle_pkg::LC_VALID_BIT] = ret.lc_valid;
    end else if (addr_w == key_lifecycle_pkg::OFF_KEY_STATUS) begin
      rdata_d[0] = &key_written;
    end else if (addr_w == key_lifecycle_pkg::OFF_KEY_SELECT) begin
      rdata_d[1:0] = key_sel_q;
    end else if (addr_w == key_lifecycle_pkg::OFF_HW_KEY_LOCK) begin
      rdata_d[0] = ret.hw_key_locked;
    end else if (addr_w == key_lifecycle_pkg::OFF_DMA_LEN) begin
      rdata_d[15:0] = dma_len_q;
    end else if (addr_w == key_lifecycle_pkg::OFF_DMA_STATUS) begin
      rdata_d[0] = dma_err_q;
    end
  end

  // One wait state: setup, first access cycle, answer in the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else if (ce) begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped(addr_w);
      prdata_q <= (psel && penable && !pready_q && !pwrite) ?
                  rdata_d : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q <= 1'b0;
      dma_out_q <= 16'h0;
      dma_err_out_q <= 1'b0;
    end else if (ce) begin
      on_q <= enable_q;
      dma_out_q <= dma_len_q;
      dma_err_out_q <= dma_err_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign subsystem_on = on_q;
  assign aes_key = aes_key_q;
  assign dma_len = dma_out_q;
  assign dma_len_err = dma_err_out_q;

endmodule

// >>> key_lifecycle_pkg.sv
// Register map, field layouts and types of the key lifecycle block
// Notes on behaviour
// - Retention keeps 4-bit lifecycle, key-usable bit, 128-bit root key.
// - Retention contents survive while the subsystem is disabled.
// - Any reset sets lifecycle state to Secure and clears key-usable bit and root key.
// - Only Debug or Secure written to the lifecycle field count as valid.
// - Validity flag turns Valid once a valid lifecycle value is written.
// - After reset lifecycle reads Secure and validity reads Invalid.
// - Valid Debug: root-key words take repeated writes, replacing old words.
// - Root key loaded by four write-only words; never readable, still usable.
// - Key-retention status reads 1 once the root key is captured.
// - Key select routes hardwired, root or session key to the AES engine.
// - Hardwired key is a fixed constant, unchangeable by any write.
// - Hardwired key is never exposed on any readable register.
// - A write of 1 locks hardwired-key use until the next reset.
// - Locked hardwired key selected feeds an all-zero key to AES.
// - DMA transaction length limited to at most 2^16-1 bytes.
// - Subsystem enable register sits at offset 0x500.
package key_lifecycle_pkg;

  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [11:0] OFF_ENABLE = 12'h500;
  localparam logic [11:0] OFF_LIFECYCLE = 12'h600;
  localparam logic [11:0] OFF_ROOT_KEY0 = 12'h610;
  localparam logic [11:0] OFF_KEY_STATUS = 12'h620;
  localparam logic [11:0] OFF_KEY_SELECT = 12'h624;
  localparam logic [11:0] OFF_HW_KEY_LOCK = 12'h628;
  localparam logic [11:0] OFF_SESSION_KEY0 = 12'h630;
  localparam logic [11:0] OFF_DMA_LEN = 12'h640;
  localparam logic [11:0] OFF_DMA_STATUS = 12'h644;

  // ********************************************************
  // Field layout and encodings
  // ********************************************************
  localparam int LC_STATE_LSB = 0;
  localparam int LC_VALID_BIT = 8;
  localparam logic [3:0] LC_DEBUG = 4'h0;
  localparam logic [3:0] LC_SECURE = 4'h2;
  localparam int KEY_WORDS = 4;
  localparam int DMA_LEN_BITS = 16;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [3:0] RST_LC_STATE = LC_SECURE;
  localparam logic RST_ENABLE = 1'b0;

  // Arbitrary hardwired key; neutral value
  localparam logic [127:0] HARDWIRED_KEY =
    128'h0123456789abcdeffedcba9876543210;

  typedef enum logic [1:0] {
    SEL_HARDWIRED = 2'b00,
    SEL_ROOT = 2'b01,
    SEL_SESSION = 2'b11
  } key_sel_t;

  typedef struct packed {
    logic [3:0] lc_state;
    logic lc_valid;
    logic hw_key_locked;
    logic [127:0] root_key;
  } retention_t;

  typedef struct packed {
    logic [127:0] key;
    logic valid;
  } aes_key_t;

endpackage

// >>> retention_domain.sv
// Always-on retention storage for lifecycle and root key
`timescale 1ns/1ps
module retention_domain (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Updates
  input wire logic lc_we,
  input wire logic [3:0] lc_wdata,
  input wire logic lock_we,
  input wire logic [3:0] key_we,
  input wire logic [31:0] key_wdata,
  // Contents
  output key_lifecycle_pkg::retention_t ret,
  output logic [3:0] key_written
);

  key_lifecycle_pkg::retention_t ret_q;
  logic [3:0] written_q;

  assign ret = ret_q;
  assign key_written = written_q;

  // Not gated by the subsystem enable, so secrets survive power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ret_q.lc_state <= key_lifecycle_pkg::RST_LC_STATE;
      ret_q.lc_valid <= 1'b0;
    end else if (ce && lc_we) begin
      if (lc_wdata == key_lifecycle_pkg::LC_DEBUG ||
          lc_wdata == key_lifecycle_pkg::LC_SECURE) begin
        ret_q.lc_state <= lc_wdata;
        ret_q.lc_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ret_q.hw_key_locked <= 1'b0;
    end else if (ce && lock_we) begin
      ret_q.hw_key_locked <= 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < key_lifecycle_pkg::KEY_WORDS; i++) begin : g_word
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ret_q.root_key[32*i +: 32] <= 32'h0;
          written_q[i] <= 1'b0;
        end else if (ce && key_we[i]) begin
          ret_q.root_key[32*i +: 32] <= key_wdata;
          written_q[i] <= 1'b1;
        end
      end
    end
  endgenerate

endmodule

// >>> key_lifecycle_monitor.sv
// Port checker of the key lifecycle register bank
`timescale 1ns/1ps
module key_lifecycle_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Control, key and DMA
  input wire logic subsystem_on,
  input wire key_lifecycle_pkg::aes_key_t aes_key,
  input wire logic [15:0] dma_len,
  input wire logic dma_len_err
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ********************************************************
  // Assertions
  // ********************************************************
  chk_ready_wait: assert property (
    psel && penable && ce && !pready |=> pready) else $error("pready late");
  chk_ready_pulse: assert property (
    pready |=> !pready) else $error("pready held");
  chk_idle_rdata: assert property (
    !pready |-> prdata == 32'h0) else $error("prdata leaks");
  chk_err_ready: assert property (
    pslverr |-> pready) else $error("lone pslverr");
  chk_key_hidden: assert property (
    pready && !pwrite && (paddr[11:4] == 8'h61 || paddr[11:4] == 8'h63)
    |-> prdata == 32'h0) else $error("key word readable");
  chk_enable_follow: assert property (
    pready && ce && pwrite && paddr == 12'h500
    |=> subsystem_on == $past(pwdata[0])) else $error("enable lost");
  chk_len_legal: assert property (
    pready && ce && pwrite && paddr == 12'h640 && pwdata[31:16] == 16'h0
    |=> dma_len == $past(pwdata[15:0]) && !dma_len_err)
    else $error("dma length not taken");
  chk_len_over: assert property (
    pready && ce && pwrite && paddr == 12'h640 && pwdata[31:16] != 16'h0
    |=> dma_len_err && $stable(dma_len)) else $error("long dma taken");
  chk_reset_clear: assert property (
    $rose(presetn) |-> !pready && !subsystem_on && aes_key == '0)
    else $error("outputs not cleared");
  // ********************************************************
  // Covers
  // ********************************************************
  cov_err: cover property (pslverr);
  cov_len_err: cover property ($rose(dma_len_err));
  cov_on: cover property ($rose(subsystem_on));
endmodule
bind crypto_key_lifecycle_ctrl key_lifecycle_monitor i_key_lifecycle_monitor (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .subsystem_on, .aes_key, .dma_len, .dma_len_err);

// >>> tb_top.sv
// Self-checking bench of the key lifecycle register bank
`timescale 1ns/1ps
module tb_top;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, subsystem_on, dma_len_err;
  logic [15:0] dma_len;
  key_lifecycle_pkg::aes_key_t aes_key;
  int fails = 0, checked = 0;
  localparam logic [127:0] K1 = 128'h11112222333344445555666677778888;
  localparam logic [127:0] K2 = 128'h9999aaaabbbbccccddddeeeeffff0001;
  localparam logic [127:0] K3 = 128'h0f0f0f0ff0f0f0f00123012345674567;
  always #5 pclk = ~pclk;
  crypto_key_lifecycle_ctrl i_crypto_key_lifecycle_ctrl (.pclk, .presetn,
    .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .subsystem_on, .aes_key, .dma_len, .dma_len_err);
  // ********************************************************
  // Bus and compare tasks
  // ********************************************************
  task automatic chk(string nm, logic [127:0] exp, logic [127:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Wait bounded; the slave sets its own pace
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    if (n >= 50) chk("pready", 1, 0);
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(0, a, 32'h0, r, e);
    chk($sformatf("rd %h", a), exp, r);
  endtask
  task automatic wkey(logic [11:0] a, logic [127:0] k);
    for (int i = 0; i < 4; i++) wr(a + 12'(4 * i), k[32 * i +: 32]);
  endtask
  task automatic key_is(string nm, logic [127:0] exp);
    repeat (3) @(posedge pclk);
    chk(nm, exp, aes_key.key);
  endtask
  task automatic do_reset();
    presetn <= 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
  endtask
  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_reset_vals();
    logic [31:0] r;
    logic e;
    rd(12'h600, 32'h2);
    rd(12'h500, 32'h0);
    rd(12'h620, 32'h0);
    apb(0, 12'h7fc, 32'h0, r, e);
    chk("unmapped err", 1, e);
  endtask
  task automatic t_debug_keys();
    wr(12'h600, 32'h5);
    rd(12'h600, 32'h2);
    wr(12'h600, 32'h0);
    rd(12'h600, 32'h100);
    wkey(12'h610, K1);
    wkey(12'h610, K2);
    rd(12'h620, 32'h1);
    rd(12'h610, 32'h0);
    wr(12'h624, 32'h1);
    wr(12'h500, 32'h1);
    key_is("root debug", K2);
    chk("on", 1, subsystem_on);
    wr(12'h500, 32'h0);
    repeat (3) @(posedge pclk);
    chk("valid off", 0, aes_key.valid);
    wr(12'h500, 32'h1);
    key_is("root kept", K2);
  endtask
  task automatic t_sel_keys();
    wkey(12'h630, K3);
    wr(12'h624, 32'h2);
    key_is("session", K3);
    rd(12'h630, 32'h0);
    wr(12'h624, 32'h0);
    key_is("hardwired", key_lifecycle_pkg::HARDWIRED_KEY);
    wr(12'h628, 32'h1);
    key_is("locked", 128'h0);
    wr(12'h628, 32'h0);
    rd(12'h628, 32'h1);
  endtask
  task automatic t_dma();
    wr(12'h640, 32'h10000);
    @(posedge pclk);
    chk("dma err", 1, dma_len_err);
    wr(12'h640, 32'hffff);
    @(posedge pclk);
    chk("dma len", 16'hffff, dma_len);
    chk("dma ok", 0, dma_len_err);
  endtask
  // Clock enable low mid-transfer must hold off the answer
  task automatic t_stall();
    int n;
    n = 0;
    fork
      wr(12'h640, 32'h1234);
      begin
        @(posedge pclk);
        ce <= 0;
        repeat (4) begin
          @(posedge pclk);
          n += pready;
        end
        ce <= 1;
      end
    join
    chk("stall ready", 0, n);
    repeat (2) @(posedge pclk);
    chk("stall len", 16'h1234, dma_len);
  endtask
  task automatic t_secure();
    do_reset();
    rd(12'h620, 32'h0);
    rd(12'h600, 32'h2);
    wr(12'h624, 32'h1);
    wr(12'h500, 32'h1);
    key_is("root cleared", 128'h0);
    wr(12'h600, 32'h2);
    rd(12'h600, 32'h102);
    wkey(12'h610, K1);
    wkey(12'h610, K2);
    wr(12'h624, 32'h1);
    wr(12'h500, 32'h1);
    key_is("root secure", K1);
  endtask
  task automatic conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200us;
    fails++;
    conclude();
  end
  initial begin
    do_reset();
    t_reset_vals();
    t_debug_keys();
    t_sel_keys();
    t_dma();
    t_stall();
    t_secure();
    conclude();
  end
endmodule
